// *** hw/rms_consts.vh ***
// register offsets, field positions, masks and reset values for the regulator mode bank
`ifndef RMS_CONSTS_VH
`define RMS_CONSTS_VH
`define RMS_IDX_BUCK_MODE 6'h1d
`define RMS_IDX_VSEL_A 6'h1e
`define RMS_IDX_VSEL_B 6'h1f
`define RMS_IDX_ENMODE_A 6'h20
`define RMS_IDX_ENMODE_B 6'h21
`define RMS_IDX_MISC 6'h22
`define RMS_BUCK3_MODE_LSB 0
`define RMS_BUCK3_HOLD_BIT 4
`define RMS_BUCK3_UOFF_BIT 5
`define RMS_BUCK4_MODE_LSB 8
`define RMS_BUCK4_HOLD_BIT 12
`define RMS_BUCK4_UOFF_BIT 13
`define RMS_BOOST_EN_BIT 20
`define RMS_BUCK_MODE_PWM 4'h5
`define RMS_BUCK_MODE_RST 4'ha
`define RMS_WMASK_BUCK 24'h10_3f3f
`define RMS_SYSMASK_BUCK 24'h00_0f0f
`define RMS_OFFMASK_BUCK 24'h00_3030
`define RMS_RST_BUCK 24'h00_0a0a
`define RMS_WMASK_VSEL_A 24'h07_5ff3
`define RMS_SYSMASK_VSEL_A 24'h07_4003
`define RMS_RST_VSEL_A 24'h02_4000
`define RMS_WMASK_VSEL_B 24'h00_01fc
`define RMS_SYSMASK_VSEL_B 24'h00_01fc
`define RMS_RST_VSEL_B 24'h00_01d8
`define RMS_WMASK_ENMODE_A 24'h1f_fe3f
`define RMS_SYSMASK_ENMODE_A 24'h1f_6c37
`define RMS_RST_ENMODE_A 24'h00_0000
`define RMS_WMASK_ENMODE_B 24'h1f_f3ef
`define RMS_SYSMASK_ENMODE_B 24'h1f_f3ef
`define RMS_RST_ENMODE_B 24'h00_0000
`define RMS_WMASK_MISC 24'h00_3fc1
`define RMS_SYSMASK_MISC 24'h00_3fc1
`define RMS_RST_MISC 24'h00_0000
`define RMS_PSLVERR_UNMAPPED 1'b1
`endif

// *** hw/rms_reg_word.v ***
// one 24-bit register word with per-bit reset domains
`timescale 1ns/1ns
module rms_reg_word #(
  parameter [23:0] WMASK = 24'h00_0000,
  parameter [23:0] SYSMASK = 24'h00_0000,
  parameter [23:0] OFFMASK = 24'h00_0000,
  parameter [23:0] RSTVAL = 24'h00_0000
) (
  // clock and resets
  input wire clock,
  input wire sys_rst,
  input wire off_rst,
  // write port
  input wire wr_en,
  input wire [23:0] wr_data,
  // optional load from sequencer
  input wire ld_en,
  input wire [23:0] ld_mask,
  input wire [23:0] ld_data,
  // contents
  output wire [23:0] value
);
  reg [23:0] word_q;
  reg [23:0] word_d;

  always @* begin
    word_d = word_q;
    if (wr_en) begin
      word_d = (word_q & ~WMASK) | (wr_data & WMASK);
    end
    if (ld_en) begin
      word_d = (word_d & ~ld_mask) | (ld_data & ld_mask);
    end
    // reset domains override by bit
    if (off_rst) begin
      word_d = (word_d & ~OFFMASK) | (RSTVAL & OFFMASK);
    end
    if (sys_rst) begin
      word_d = (word_d & ~SYSMASK) | (RSTVAL & SYSMASK);
    end
    // (RQ21) unused bits zero
    word_d = word_d & WMASK;
  end

  always @(posedge clock) begin
    word_q <= word_d;
  end

  assign value = word_q;
endmodule // rms_reg_word

// *** hw/rms_regulator_mode_regs.v ***
// regulator mode setting register bank with apb slave
//
// Overview of operation
// (RQ1) each sequencer run reloads both buck mode fields from the strap-chosen default.
// (RQ2) enabled bucks default to fixed pwm, no skipping, normal and standby; with the strap high the code loads 1010 instead.
// (RQ3) buck3 mode bits 0-3 reset 1010; hold bit 4, user-off bit 5 off-reset.
// (RQ4) buck4 mode bits 8-11 reset 1010; hold bit 12, user-off bit 13 off-reset.
// (RQ5) boost enable bit 20, never reset, set by power-up configuration.
// (RQ6) ldo1 enable, standby, mode at bits 0-2, system reset to 0.
// (RQ7) io-high enable bit 3 unreset; standby bit 4 system reset to 0.
// (RQ8) digital ldo enable bit 9 unreset; standby bit 10 resets to 0.
// (RQ9) ldo2 enable bit 12 unreset; standby 13 and mode 14 reset 0.
// (RQ10) pll ldo enable bit 15 unreset; standby bit 16 resets to 0.
// (RQ11) usb aux enable bit 18 and standby bit 19 reset to 0.
// (RQ12) ldo3 enable, standby, mode, external pass at bits 0-3, reset 0.
// (RQ13) camera ldo enable, standby, mode, external pass at bits 6-9, reset 0.
// (RQ14) video ldo enable 12, standby 13, mode 14, reset to 0.
// (RQ15) audio ldo enable 15 and standby 16, reset to 0.
// (RQ16) card ldo enable 18, standby 19, mode 20, reset to 0.
// (RQ17) short-circuit protect enable misc bit 0, reset off.
// (RQ18) general outputs 1-4 enable/standby pairs bits 6-13, reset 0.
// (RQ19) voltage select a fields with their reset or unreset defaults.
// (RQ20) voltage select b: video 10, audio 01, card 111 on reset.
// (RQ21) unused bits read 0 and ignore writes; spares are plain storage.
// (RQ22) 24-bit words read and written by register number.
`timescale 1ns/1ns
`include "rms_consts.vh"
module rms_regulator_mode_regs #(
  parameter [3:0] BUCK_MODE_STRAP0 = `RMS_BUCK_MODE_PWM,
  parameter [3:0] BUCK_MODE_STRAP1 = `RMS_BUCK_MODE_RST
) (
  // clock and resets
  input wire clock,
  input wire sys_rst,
  input wire off_rst,
  // power-up sequencer
  input wire seq_run,
  input wire power_up_strap_selection,
  input wire [23:0] seq_cfg_data,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // register contents to the analog side
  output reg [23:0] buck_boost_mode_control,
  output reg [23:0] ldo_voltage_select_a,
  output reg [23:0] ldo_voltage_select_b,
  output reg [23:0] ldo_enable_mode_a,
  output reg [23:0] ldo_enable_mode_b,
  output reg [23:0] power_misc_control
);
  wire [23:0] buck_w;
  wire [23:0] vsa_w;
  wire [23:0] vsb_w;
  wire [23:0] ema_w;
  wire [23:0] emb_w;
  wire [23:0] misc_w;
  reg [2:0] seq_sync_q;
  reg seq_level_q;
  reg seq_prev_q;
  reg [2:0] strap_sync_q;
  reg strap_q;
  reg seq_pulse_d;
  reg [3:0] buck_dflt_d;
  reg [23:0] seq_mask_d;
  reg [23:0] seq_data_d;
  reg acc_q;
  reg [31:0] rdata_d;
  reg hit_d;
  reg ready_d;
  reg err_d;
  reg [31:0] resp_d;
  wire [5:0] idx;
  wire wr_go;
  wire wr_buck;
  wire wr_vsa;
  wire wr_vsb;
  wire wr_ema;
  wire wr_emb;
  wire wr_misc;

  function is_mapped;
    input [31:0] a;
    begin
      is_mapped = (a[1:0] == 2'b00) && (a[31:8] == 24'h00_0000) &&
        (a[7:2] >= `RMS_IDX_BUCK_MODE) && (a[7:2] <= `RMS_IDX_MISC);
    end
  endfunction

  // write strobe of one register word
  function sel_write;
    input go;
    input [5:0] at;
    input [5:0] code;
    begin
      sel_write = go && (at == code);
    end
  endfunction

  // sequencer start and strap: three flip-flops, a change counts once the last two agree
  always @(posedge clock) begin
    if (sys_rst) begin
      seq_sync_q <= 3'b000;
      seq_level_q <= 1'b0;
      seq_prev_q <= 1'b0;
      strap_sync_q <= 3'b000;
      strap_q <= 1'b0;
    end else begin
      seq_sync_q <= {seq_sync_q[1:0], seq_run};
      strap_sync_q <= {strap_sync_q[1:0], power_up_strap_selection};
      if (seq_sync_q[2] == seq_sync_q[1]) begin
        seq_level_q <= seq_sync_q[2];
      end
      seq_prev_q <= seq_level_q;
      if (strap_sync_q[2] == strap_sync_q[1]) begin
        strap_q <= strap_sync_q[2];
      end
    end
  end

  always @* begin
    // settled rising level starts one reload
    seq_pulse_d = seq_level_q & ~seq_prev_q;
    // (RQ1) strap picks default
    buck_dflt_d = strap_q ? BUCK_MODE_STRAP1 : BUCK_MODE_STRAP0;
    // (RQ2) default mode: pwm with strap low, reset mode 1010 with strap high
    seq_mask_d = 24'h00_0000;
    seq_mask_d[`RMS_BUCK3_MODE_LSB +: 4] = 4'hf;
    seq_mask_d[`RMS_BUCK4_MODE_LSB +: 4] = 4'hf;
    seq_mask_d[`RMS_BOOST_EN_BIT] = 1'b1;
    seq_data_d = 24'h00_0000;
    seq_data_d[`RMS_BUCK3_MODE_LSB +: 4] = buck_dflt_d;
    seq_data_d[`RMS_BUCK4_MODE_LSB +: 4] = buck_dflt_d;
    // (RQ5) boost from config
    seq_data_d[`RMS_BOOST_EN_BIT] = seq_cfg_data[`RMS_BOOST_EN_BIT];
  end

  // apb access phase takes one wait-free cycle
  assign idx = paddr[7:2];
  // (RQ22) write by register number
  assign wr_go = psel & penable & pwrite & ~acc_q & is_mapped(paddr);
  // one write strobe per register word
  assign wr_buck = sel_write(wr_go, idx, `RMS_IDX_BUCK_MODE);
  assign wr_vsa = sel_write(wr_go, idx, `RMS_IDX_VSEL_A);
  assign wr_vsb = sel_write(wr_go, idx, `RMS_IDX_VSEL_B);
  assign wr_ema = sel_write(wr_go, idx, `RMS_IDX_ENMODE_A);
  assign wr_emb = sel_write(wr_go, idx, `RMS_IDX_ENMODE_B);
  assign wr_misc = sel_write(wr_go, idx, `RMS_IDX_MISC);

  // (RQ3) buck3 fields
  // (RQ4) buck4 fields
  rms_reg_word #(
    .WMASK(`RMS_WMASK_BUCK),
    .SYSMASK(`RMS_SYSMASK_BUCK),
    .OFFMASK(`RMS_OFFMASK_BUCK),
    .RSTVAL(`RMS_RST_BUCK)
  ) u_buck (
    .clock(clock),
    .sys_rst(sys_rst),
    .off_rst(off_rst),
    .wr_en(wr_buck),
    .wr_data(pwdata[23:0]),
    .ld_en(seq_pulse_d),
    .ld_mask(seq_mask_d),
    .ld_data(seq_data_d),
    .value(buck_w)
  );

  // (RQ19) voltage select a
  rms_reg_word #(
    .WMASK(`RMS_WMASK_VSEL_A),
    .SYSMASK(`RMS_SYSMASK_VSEL_A),
    .OFFMASK(24'h00_0000),
    .RSTVAL(`RMS_RST_VSEL_A)
  ) u_vsa (
    .clock(clock),
    .sys_rst(sys_rst),
    .off_rst(off_rst),
    .wr_en(wr_vsa),
    .wr_data(pwdata[23:0]),
    .ld_en(1'b0),
    .ld_mask(24'h00_0000),
    .ld_data(24'h00_0000),
    .value(vsa_w)
  );

  // (RQ20) voltage select b
  rms_reg_word #(
    .WMASK(`RMS_WMASK_VSEL_B),
    .SYSMASK(`RMS_SYSMASK_VSEL_B),
    .OFFMASK(24'h00_0000),
    .RSTVAL(`RMS_RST_VSEL_B)
  ) u_vsb (
    .clock(clock),
    .sys_rst(sys_rst),
    .off_rst(off_rst),
    .wr_en(wr_vsb),
    .wr_data(pwdata[23:0]),
    .ld_en(1'b0),
    .ld_mask(24'h00_0000),
    .ld_data(24'h00_0000),
    .value(vsb_w)
  );

  // (RQ6) ldo1 bits
  // (RQ7) io-high bits
  // (RQ8) digital ldo bits
  // (RQ9) ldo2 bits
  // (RQ10) pll ldo bits
  // (RQ11) usb aux bits
  rms_reg_word #(
    .WMASK(`RMS_WMASK_ENMODE_A),
    .SYSMASK(`RMS_SYSMASK_ENMODE_A),
    .OFFMASK(24'h00_0000),
    .RSTVAL(`RMS_RST_ENMODE_A)
  ) u_ema (
    .clock(clock),
    .sys_rst(sys_rst),
    .off_rst(off_rst),
    .wr_en(wr_ema),
    .wr_data(pwdata[23:0]),
    .ld_en(1'b0),
    .ld_mask(24'h00_0000),
    .ld_data(24'h00_0000),
    .value(ema_w)
  );

  // (RQ12) ldo3 bits
  // (RQ13) camera ldo bits
  // (RQ14) video ldo bits
  // (RQ15) audio ldo bits
  // (RQ16) card ldo bits
  rms_reg_word #(
    .WMASK(`RMS_WMASK_ENMODE_B),
    .SYSMASK(`RMS_SYSMASK_ENMODE_B),
    .OFFMASK(24'h00_0000),
    .RSTVAL(`RMS_RST_ENMODE_B)
  ) u_emb (
    .clock(clock),
    .sys_rst(sys_rst),
    .off_rst(off_rst),
    .wr_en(wr_emb),
    .wr_data(pwdata[23:0]),
    .ld_en(1'b0),
    .ld_mask(24'h00_0000),
    .ld_data(24'h00_0000),
    .value(emb_w)
  );

  // (RQ17) protect enable
  // (RQ18) general outputs
  rms_reg_word #(
    .WMASK(`RMS_WMASK_MISC),
    .SYSMASK(`RMS_SYSMASK_MISC),
    .OFFMASK(24'h00_0000),
    .RSTVAL(`RMS_RST_MISC)
  ) u_misc (
    .clock(clock),
    .sys_rst(sys_rst),
    .off_rst(off_rst),
    .wr_en(wr_misc),
    .wr_data(pwdata[23:0]),
    .ld_en(1'b0),
    .ld_mask(24'h00_0000),
    .ld_data(24'h00_0000),
    .value(misc_w)
  );

  // (RQ22) read by register number
  always @* begin
    hit_d = is_mapped(paddr);
    rdata_d = 32'h0000_0000;
    case (idx)
      `RMS_IDX_BUCK_MODE: begin
        rdata_d = {8'h00, buck_w};
      end
      `RMS_IDX_VSEL_A: begin
        rdata_d = {8'h00, vsa_w};
      end
      `RMS_IDX_VSEL_B: begin
        rdata_d = {8'h00, vsb_w};
      end
      `RMS_IDX_ENMODE_A: begin
        rdata_d = {8'h00, ema_w};
      end
      `RMS_IDX_ENMODE_B: begin
        rdata_d = {8'h00, emb_w};
      end
      `RMS_IDX_MISC: begin
        rdata_d = {8'h00, misc_w};
      end
      default: begin
        rdata_d = 32'h0000_0000;
      end
    endcase
    if (!hit_d) begin
      rdata_d = 32'h0000_0000;
    end
  end

  // answer for the access cycle, worked out in the setup cycle
  always @* begin
    ready_d = 1'b0;
    err_d = 1'b0;
    resp_d = 32'h0000_0000;
    if (psel && !penable) begin
      ready_d = 1'b1;
      err_d = ~hit_d & `RMS_PSLVERR_UNMAPPED;
      if (!pwrite) begin
        resp_d = rdata_d;
      end
    end
  end

  // apb answer: pready high in the cycle after the setup phase
  always @(posedge clock) begin
    if (sys_rst) begin
      acc_q <= 1'b0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      acc_q <= psel & penable & ~acc_q;
      pready <= ready_d;
      pslverr <= err_d;
      prdata <= resp_d;
    end
  end

  // outputs from flip-flops
  always @(posedge clock) begin
    buck_boost_mode_control <= buck_w;
    ldo_voltage_select_a <= vsa_w;
    ldo_voltage_select_b <= vsb_w;
    ldo_enable_mode_a <= ema_w;
    ldo_enable_mode_b <= emb_w;
    power_misc_control <= misc_w;
  end
endmodule // rms_regulator_mode_regs

// *** verif/rms_chk_asserts.sv ***
// assertion checker for the regulator mode register bank
`timescale 1ns/1ns
module rms_chk #(
  parameter [3:0] BUCK_MODE_STRAP0 = 4'h5,
  parameter [3:0] BUCK_MODE_STRAP1 = 4'ha
) (
  // clock and resets
  input wire clock,
  input wire sys_rst,
  input wire off_rst,
  // sequencer
  input wire seq_run,
  input wire power_up_strap_selection,
  input wire [23:0] seq_cfg_data,
  // apb
  input wire psel,
  input wire penable,
  input wire [31:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // contents
  input wire [23:0] buck_boost_mode_control,
  input wire [23:0] ldo_voltage_select_b,
  input wire [23:0] ldo_enable_mode_b,
  input wire [23:0] power_misc_control
);
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire setup = psel && !penable;
  wire bad_addr = paddr < 32'h0000_0074 || paddr > 32'h0000_0088 || paddr[1:0] != 2'b00;
  wire [3:0] strap_mode = power_up_strap_selection ? BUCK_MODE_STRAP1 : BUCK_MODE_STRAP0;
  wire [23:0] bk = buck_boost_mode_control;
  a_ready_next: assert property (setup |=> pready) else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_err_flag: assert property (setup |=> pslverr == $past(bad_addr)) else $error("bad error flag");
  a_err_nodata: assert property (pready && pslverr |-> prdata == 32'h0000_0000) else $error("error data");
  a_upper_zero: assert property (pready |-> prdata[31:24] == 8'h00) else $error("upper byte set");
  a_unused_zero: assert property ((bk & ~24'h10_3f3f) == 24'h00_0000
    && (ldo_enable_mode_b & ~24'h1f_f3ef) == 24'h00_0000
    && (ldo_voltage_select_b & ~24'h00_01fc) == 24'h00_0000) else $error("unused bit set");
  a_reset_dflt: assert property ($fell(sys_rst) |=> (bk & 24'h00_0f0f) == 24'h00_0a0a
    && ldo_voltage_select_b == 24'h00_01d8
    && ldo_enable_mode_b == 24'h00_0000 && power_misc_control[13:0] == 14'h0000) else $error("bad reset value");
  a_offrst_clear: assert property ($fell(off_rst) |=> (bk & 24'h00_3030) == 24'h00_0000) else $error("off bits kept");
  a_seq_load: assert property ($rose(seq_run) |-> ##[2:16] (bk[3:0] == strap_mode
    && bk[11:8] == strap_mode && bk[20] == seq_cfg_data[20])) else $error("no sequencer reload");
  c_write: cover property (pready && !pslverr);
  c_error: cover property (pready && pslverr);
  c_seq: cover property ($rose(seq_run));
endmodule // rms_chk

bind rms_regulator_mode_regs rms_chk #(.BUCK_MODE_STRAP0(BUCK_MODE_STRAP0), .BUCK_MODE_STRAP1(BUCK_MODE_STRAP1)) u_chk (
  .clock, .sys_rst, .off_rst, .seq_run, .power_up_strap_selection, .seq_cfg_data, .psel, .penable, .paddr,
  .prdata, .pready, .pslverr, .buck_boost_mode_control, .ldo_voltage_select_b, .ldo_enable_mode_b,
  .power_misc_control);

// *** verif/tb_top.sv ***
// self-checking bench for the regulator mode register bank
`timescale 1ns/1ns
module tb_top;
  logic clock = 1'b0;
  logic sys_rst = 1'b1;
  logic off_rst = 1'b1;
  logic seq_run = 1'b0;
  logic power_up_strap_selection = 1'b0;
  logic [23:0] seq_cfg_data = 24'h00_0000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire [143:0] outs;
  int bad_count = 0;
  int checks_done = 0;
  logic [23:0] wm [6] = '{24'h10_3f3f, 24'h07_5ff3, 24'h00_01fc, 24'h1f_fe3f, 24'h1f_f3ef, 24'h00_3fc1};
  logic [23:0] sm [6] = '{24'h00_0f0f, 24'h07_4003, 24'h00_01fc, 24'h1f_6c37, 24'h1f_f3ef, 24'h00_3fc1};
  logic [23:0] rv [6] = '{24'h00_0a0a, 24'h02_4000, 24'h00_01d8, 24'h00_0000, 24'h00_0000, 24'h00_0000};
  logic [31:0] bad [4] = '{32'h0000_0070, 32'h0000_008c, 32'h0000_0075, 32'h0001_0074};
  logic [23:0] ex [6];
  logic [23:0] kn [6];
  logic [31:0] r;
  logic e;
  always #5 clock = ~clock;
  rms_regulator_mode_regs dut (.clock, .sys_rst, .off_rst, .seq_run, .power_up_strap_selection, .seq_cfg_data,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .buck_boost_mode_control(outs[23:0]), .ldo_voltage_select_a(outs[47:24]), .ldo_voltage_select_b(outs[71:48]),
    .ldo_enable_mode_a(outs[95:72]), .ldo_enable_mode_b(outs[119:96]), .power_misc_control(outs[143:120]));
  task automatic end_of_test();
    if (bad_count == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] want);
    checks_done++;
    if (got !== want) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, want);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input int i, input logic [31:0] d);
    apb(1'b1, 32'h0000_0074 + 4 * i, d);
    chk({32'h0000_0000, e}, 33'h0);
    ex[i] = d[23:0] & wm[i];
    kn[i] = 24'hff_ffff;
  endtask
  task automatic rd(input int i);
    logic [23:0] m;
    m = kn[i] & (i == 5 ? 24'h00_7fff : 24'hff_ffff);
    apb(1'b0, 32'h0000_0074 + 4 * i, 32'h0000_0000);
    chk({e, r & {8'hff, m}}, {9'h000, ex[i] & m});
    chk({9'h000, outs[i * 24 +: 24] & m}, {9'h000, ex[i] & m});
  endtask
  task automatic rd_all();
    for (int i = 0; i < 6; i++) rd(i);
  endtask
  task automatic wr_all(input logic [31:0] d, input logic rnd);
    for (int i = 0; i < 6; i++) wr(i, rnd ? $urandom : d);
  endtask
  task automatic pulse_rst(input logic s, input logic o, input int n);
    sys_rst <= s;
    off_rst <= o;
    repeat (n) @(posedge clock);
    sys_rst <= 1'b0;
    off_rst <= 1'b0;
    for (int i = 0; i < 6; i++) if (s) ex[i] = (ex[i] & ~sm[i]) | rv[i];
    if (o) ex[0] = ex[0] & ~24'h00_3030;
  endtask
  task automatic seq(input logic s, input logic [23:0] cfg);
    logic [3:0] m;
    m = s ? 4'ha : 4'h5;
    power_up_strap_selection <= s;
    seq_cfg_data <= cfg;
    repeat (8) @(posedge clock);
    seq_run <= 1'b1;
    repeat (20) @(posedge clock);
    seq_run <= 1'b0;
    ex[0] = (ex[0] & ~24'h10_0f0f) | {3'b000, cfg[20], 8'h00, m, 4'h0, m};
    kn[0] = 24'hff_ffff;
    rd(0);
  endtask
  initial begin
    #100000;
    bad_count++;
    end_of_test();
  end
  initial begin
    void'($urandom(8154));
    for (int i = 0; i < 6; i++) begin
      ex[i] = 24'h00_0000;
      kn[i] = ~(wm[i] & ~sm[i] & ~(i == 0 ? 24'h00_3030 : 24'h00_0000));
    end
    pulse_rst(1'b1, 1'b1, 4);
    rd_all();
    wr_all(32'hffff_ffff, 1'b0);
    rd_all();
    wr_all(32'h0000_0000, 1'b0);
    rd_all();
    repeat (30) begin
      int j;
      j = $urandom_range(5);
      wr(j, $urandom);
      rd(j);
    end
    foreach (bad[k]) begin
      apb(1'b1, bad[k], 32'hffff_ffff);
      chk({e, 32'h0000_0000}, {1'b1, 32'h0000_0000});
      apb(1'b0, bad[k], 32'h0000_0000);
      chk({e, r}, {1'b1, 32'h0000_0000});
    end
    rd_all();
    wr(0, 32'h0000_3a3a);
    seq(1'b0, 24'h10_0000);
    seq(1'b1, 24'h00_0000);
    wr_all(32'h0000_0000, 1'b1);
    pulse_rst(1'b1, 1'b0, 2);
    rd_all();
    pulse_rst(1'b0, 1'b1, 2);
    rd_all();
    end_of_test();
  end
endmodule // tb_top
